// file: logic/pcrb_pkg.sv
package pcrb_pkg;
  // ----------------------------------------
  // register offsets (byte addresses)
  // ----------------------------------------
  localparam logic [11:0] OFF_LINK_STATUS_CONTROL_2 = 12'h098;
  localparam logic [11:0] OFF_SUBSYSTEM_CAPABILITY_HEADER = 12'h0A4;
  localparam logic [11:0] OFF_BOARD_VENDOR_AND_BOARD_ID = 12'h0A8;
  localparam logic [11:0] OFF_SERIAL_NUMBER_CAP_HEADER = 12'h100;
  localparam logic [11:0] OFF_SERIAL_NUMBER_LOW = 12'h104;
  localparam logic [11:0] OFF_SERIAL_NUMBER_HIGH = 12'h108;
  localparam logic [11:0] OFF_POWER_BUDGET_CAP_HEADER = 12'h138;
  localparam logic [11:0] OFF_POWER_BUDGET_INDEX = 12'h13C;
  localparam logic [11:0] OFF_POWER_BUDGET_ENTRY = 12'h140;
  localparam logic [11:0] OFF_POWER_BUDGET_CAPABILITY = 12'h144;

  // ----------------------------------------
  // link control/status 2 field positions
  // ----------------------------------------
  localparam int LC2_ENTER_COMPLIANCE = 4;
  localparam int LC2_HW_AUTO_SPEED_DIS = 5;
  localparam int LC2_SEL_DEEMPH = 6;
  localparam int LC2_TX_MARGIN_LO = 7;
  localparam int LC2_TX_MARGIN_HI = 9;
  localparam int LC2_ENTER_MOD_COMPLIANCE = 10;
  localparam int LC2_COMPLIANCE_SKIP = 11;
  localparam int LC2_COMPLIANCE_DEEMPH = 12;
  localparam int LC2_CUR_DEEMPH = 16;

  // ----------------------------------------
  // capability headers
  // ----------------------------------------
  localparam logic [7:0] SUBSYS_CAP_ID = 8'h0D;
  localparam logic [7:0] SUBSYS_NEXT_PTR = 8'h00;
  localparam logic [11:0] EXT_CAP_FIRST = 12'h100;
  localparam logic [15:0] SERIAL_CAP_ID = 16'h0003;
  localparam logic [3:0] SERIAL_CAP_VER = 4'h1;
  localparam logic [11:0] SERIAL_NEXT = 12'hFB4;
  localparam logic [15:0] PWR_CAP_ID = 16'h0004;
  localparam logic [3:0] PWR_CAP_VER = 4'h1;
  localparam logic [11:0] PWR_NEXT = 12'h148;

  // ----------------------------------------
  // power budget entry layout
  // ----------------------------------------
  localparam int PB_ENTRIES = 8;
  localparam int PB_IDX_W = 3;
  localparam int PB_W = 21;
  localparam int PB_BASE_HI = 7;
  localparam int PB_SCALE_HI = 9;
  localparam int PB_SUBSTATE_HI = 12;
  localparam int PB_STATE_HI = 14;
  localparam int PB_TYPE_HI = 17;
  localparam int PB_RAIL_HI = 20;
  localparam logic [7:0] PB_INDEX_RESET = 8'h00;
  localparam logic PB_SYSTEM_ALLOCATED_RESET = 1'b1;

  // ----------------------------------------
  // reset values of identity fields (arbitrary neutral values)
  // ----------------------------------------
  localparam logic [15:0] BOARD_VENDOR_ID_RESET = 16'h0001;
  localparam logic [15:0] BOARD_ID_RESET = 16'h0001;
  localparam logic [63:0] SERIAL_NUMBER_RESET = 64'h0000_0000_0000_0001;
endpackage : pcrb_pkg

// file: logic/pcrb_power_budget_store.sv
`timescale 1ns/1ps
module pcrb_power_budget_store (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic [7:0] index_i,
  input wire logic load_i,
  input wire logic [pcrb_pkg::PB_W-1:0] load_data_i,
  output logic [31:0] entry_o
);
  import pcrb_pkg::*;

  logic [PB_W-1:0] entry [PB_ENTRIES];
  logic in_range;

  // indices 8 and up select nothing
  assign in_range = (index_i[7:PB_IDX_W] == '0);

  // ----------------------------------------
  // eight independent entries
  // ----------------------------------------
  for (genvar g = 0; g < PB_ENTRIES; g++) begin : g_entry
    always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
        entry[g] <= '0;
      end else if (load_i && in_range && (index_i[PB_IDX_W-1:0] == PB_IDX_W'(g))) begin
        entry[g] <= load_data_i;
      end
    end
  end

  // base/scale/substate/state/type/rail packed in bits 20:0, upper bits zero
  assign entry_o = in_range ? {11'h000, entry[index_i[PB_IDX_W-1:0]]} : 32'h0000_0000;
endmodule : pcrb_power_budget_store

// file: logic/pcrb_port_capability_register_bank.sv
`timescale 1ns/1ps
// How it works
// - downstream 5 GT/s: select bit picks de-emphasis
// - autonomous speed disable bit reserved, never blocks
// - skip bit inserts skip sets in compliance
// - compliance de-emphasis only after enter-compliance entry
// - modified compliance only upstream function 0
// - bit 16 reports de-emphasis in use
// - subsystem header: id 0Dh, next 00h
// - extended chain starts at 100h
// - board ids read-only, loadable by init
// - serial header: 0003h, version 1, next FB4h
// - one shared 64-bit serial number register
// - low 24 company, upper 40 extension
// - upstream power header 0004h/1/148h, downstream zero
// - 8-bit index, reset 00h, selects entry
// - eight independent entries, loaded by init path
// - base power 7:0, scale 9:8
// - sub-state 12:10, state 14:13
// - condition type in bits 17:15
// - supply rail in bits 20:18
// - upstream system allocated bit resets to 1
module pcrb_port_capability_register_bank (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic is_upstream_i,
  input wire logic is_function0_i,
  input wire logic link_speed_5g_i,
  input wire logic polling_compliance_i,
  input wire logic cfg_wr_i,
  input wire logic cfg_rd_i,
  input wire logic [11:0] cfg_addr_i,
  input wire logic [31:0] cfg_wdata_i,
  input wire logic init_wr_i,
  input wire logic [11:0] init_addr_i,
  input wire logic [31:0] init_wdata_i,
  output logic [31:0] cfg_rdata_o,
  output logic cfg_rvalid_o,
  output logic deemph_3p5db_o,
  output logic enter_compliance_o,
  output logic enter_mod_compliance_o,
  output logic compliance_skip_insert_o,
  output logic [2:0] tx_margin_o,
  output logic [63:0] serial_number_o
);
  import pcrb_pkg::*;

  // ----------------------------------------
  // pin synchroniser for the link speed
  // ----------------------------------------
  // pin is free-running against clk_i; only speed_5g feeds logic
  logic speed_meta;
  logic speed_5g;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      speed_meta <= 1'b0;
      speed_5g <= 1'b0;
    end else begin
      speed_meta <= link_speed_5g_i;
      speed_5g <= speed_meta;
    end
  end

  // ----------------------------------------
  // write decode
  // ----------------------------------------
  logic any_wr;
  logic [11:0] wr_addr;
  logic [31:0] wr_data;

  // init path (eeprom / i2c / smbus) also reaches fields that are read-only to software
  assign any_wr = cfg_wr_i | init_wr_i;
  assign wr_addr = init_wr_i ? init_addr_i : cfg_addr_i;
  assign wr_data = init_wr_i ? init_wdata_i : cfg_wdata_i;

  // ----------------------------------------
  // per-register write strobes
  // ----------------------------------------
  // decoded once so each register block reads ready-made strobes; the serial number block reads two
  logic lc2_wr;
  logic lc2_init_wr;
  logic index_wr;
  logic board_init_wr;
  logic serial_lo_init_wr;
  logic serial_hi_init_wr;
  logic pwr_cap_init_wr;

  assign lc2_wr = any_wr && wr_addr == OFF_LINK_STATUS_CONTROL_2;
  assign lc2_init_wr = init_wr_i && init_addr_i == OFF_LINK_STATUS_CONTROL_2;
  assign index_wr = any_wr && wr_addr == OFF_POWER_BUDGET_INDEX && is_upstream_i;
  assign board_init_wr = init_wr_i && init_addr_i == OFF_BOARD_VENDOR_AND_BOARD_ID;
  assign serial_lo_init_wr = init_wr_i && init_addr_i == OFF_SERIAL_NUMBER_LOW;
  assign serial_hi_init_wr = init_wr_i && init_addr_i == OFF_SERIAL_NUMBER_HIGH;
  assign pwr_cap_init_wr = init_wr_i && init_addr_i == OFF_POWER_BUDGET_CAPABILITY;

  // ----------------------------------------
  // link control 2 upper fields
  // ----------------------------------------
  logic enter_compliance;
  logic sel_deemph;
  logic [2:0] tx_margin;
  logic enter_mod_compliance;
  logic compliance_skip;
  logic compliance_deemph;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      enter_compliance <= 1'b0;
      tx_margin <= 3'h0;
      enter_mod_compliance <= 1'b0;
      compliance_skip <= 1'b0;
      compliance_deemph <= 1'b0;
    end else if (lc2_wr) begin
      // bit 5 is not stored at all
      enter_compliance <= wr_data[LC2_ENTER_COMPLIANCE];
      if (is_upstream_i) begin
        tx_margin <= wr_data[LC2_TX_MARGIN_HI:LC2_TX_MARGIN_LO];
        enter_mod_compliance <= wr_data[LC2_ENTER_MOD_COMPLIANCE] & is_function0_i;
        compliance_skip <= wr_data[LC2_COMPLIANCE_SKIP];
        compliance_deemph <= wr_data[LC2_COMPLIANCE_DEEMPH];
      end
    end
  end

  // select bit is loaded only by the init path on downstream ports
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      sel_deemph <= 1'b0;
    end else if (lc2_init_wr && !is_upstream_i) begin
      sel_deemph <= init_wdata_i[LC2_SEL_DEEMPH];
    end
  end

  // ----------------------------------------
  // compliance entry cause
  // ----------------------------------------
  logic in_compliance_d;
  logic entered_by_bit4;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      in_compliance_d <= 1'b0;
    end else begin
      in_compliance_d <= polling_compliance_i;
    end
  end

  // cause is frozen at entry; later writes to bit 4 do not change it
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      entered_by_bit4 <= 1'b0;
    end else if (polling_compliance_i && !in_compliance_d) begin
      entered_by_bit4 <= enter_compliance;
    end else if (!polling_compliance_i) begin
      entered_by_bit4 <= 1'b0;
    end
  end

  // ----------------------------------------
  // de-emphasis in use
  // ----------------------------------------
  logic deemph_3p5;

  // compliance override first, then line rate, then port role
  always_comb begin
    if (is_upstream_i && polling_compliance_i && entered_by_bit4) begin
      deemph_3p5 = compliance_deemph;
    end else if (!speed_5g) begin
      deemph_3p5 = 1'b1;
    end else if (!is_upstream_i) begin
      deemph_3p5 = sel_deemph;
    end else begin
      deemph_3p5 = 1'b0;
    end
  end

  // data output from a flop, one cycle behind the cause
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      deemph_3p5db_o <= 1'b1;
    end else begin
      deemph_3p5db_o <= deemph_3p5;
    end
  end

  assign enter_compliance_o = enter_compliance;
  assign enter_mod_compliance_o = enter_mod_compliance & is_upstream_i & is_function0_i;
  assign compliance_skip_insert_o = compliance_skip & is_upstream_i;
  assign tx_margin_o = tx_margin;

  // ----------------------------------------
  // board ids and serial number
  // ----------------------------------------
  logic [15:0] board_vendor_id;
  logic [15:0] board_id;
  logic [63:0] serial_number;

  // software writes never reach these; only the init path does
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      board_vendor_id <= BOARD_VENDOR_ID_RESET;
      board_id <= BOARD_ID_RESET;
    end else if (board_init_wr) begin
      board_vendor_id <= init_wdata_i[15:0];
      board_id <= init_wdata_i[31:16];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      serial_number <= SERIAL_NUMBER_RESET;
    end else if (serial_lo_init_wr) begin
      serial_number[31:0] <= init_wdata_i;
    end else if (serial_hi_init_wr) begin
      serial_number[63:32] <= init_wdata_i;
    end
  end

  // other ports read this same copy rather than keeping their own
  assign serial_number_o = serial_number;

  // ----------------------------------------
  // power budget
  // ----------------------------------------
  logic [7:0] pb_index;
  logic pb_system_allocated;
  logic [31:0] pb_entry;
  logic pb_load;

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pb_index <= PB_INDEX_RESET;
    end else if (index_wr) begin
      pb_index <= wr_data[7:0];
    end
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      pb_system_allocated <= PB_SYSTEM_ALLOCATED_RESET;
    end else if (pwr_cap_init_wr) begin
      pb_system_allocated <= init_wdata_i[0];
    end
  end

  // entry value lands at whatever index was written before it
  assign pb_load = init_wr_i && init_addr_i == OFF_POWER_BUDGET_ENTRY && is_upstream_i;

  pcrb_power_budget_store u_store (
    .clk_i(clk_i),
    .rst_n_i(rst_n_i),
    .index_i(pb_index),
    .load_i(pb_load),
    .load_data_i(init_wdata_i[PB_W-1:0]),
    .entry_o(pb_entry)
  );

  // ----------------------------------------
  // link control/status 2 read image
  // ----------------------------------------
  logic [31:0] lc2_image;

  // reserved positions, bit 5 among them, stay zero
  always_comb begin
    lc2_image = 32'h0000_0000;
    lc2_image[LC2_ENTER_COMPLIANCE] = enter_compliance;
    lc2_image[LC2_HW_AUTO_SPEED_DIS] = 1'b0;
    lc2_image[LC2_SEL_DEEMPH] = sel_deemph & ~is_upstream_i;
    lc2_image[LC2_TX_MARGIN_HI:LC2_TX_MARGIN_LO] = tx_margin;
    lc2_image[LC2_ENTER_MOD_COMPLIANCE] = enter_mod_compliance;
    lc2_image[LC2_COMPLIANCE_SKIP] = compliance_skip;
    lc2_image[LC2_COMPLIANCE_DEEMPH] = compliance_deemph;
    lc2_image[LC2_CUR_DEEMPH] = deemph_3p5db_o;
  end

  // ----------------------------------------
  // read mux
  // ----------------------------------------
  logic [31:0] next_rdata;

  always_comb begin
    next_rdata = 32'h0000_0000;
    case (cfg_addr_i)
      OFF_LINK_STATUS_CONTROL_2: begin
        next_rdata = lc2_image;
      end
      OFF_SUBSYSTEM_CAPABILITY_HEADER: begin
        next_rdata = {16'h0000, SUBSYS_NEXT_PTR, SUBSYS_CAP_ID};
      end
      OFF_BOARD_VENDOR_AND_BOARD_ID: begin
        next_rdata = {board_id, board_vendor_id};
      end
      EXT_CAP_FIRST: begin
        next_rdata = {SERIAL_NEXT, SERIAL_CAP_VER, SERIAL_CAP_ID};
      end
      OFF_SERIAL_NUMBER_LOW: begin
        next_rdata = serial_number[31:0];
      end
      OFF_SERIAL_NUMBER_HIGH: begin
        next_rdata = serial_number[63:32];
      end
      OFF_POWER_BUDGET_CAP_HEADER: begin
        if (is_upstream_i) begin
          next_rdata = {PWR_NEXT, PWR_CAP_VER, PWR_CAP_ID};
        end
      end
      OFF_POWER_BUDGET_INDEX: begin
        if (is_upstream_i) begin
          next_rdata = {24'h000000, pb_index};
        end
      end
      OFF_POWER_BUDGET_ENTRY: begin
        if (is_upstream_i) begin
          next_rdata = pb_entry;
        end
      end
      OFF_POWER_BUDGET_CAPABILITY: begin
        if (is_upstream_i) begin
          next_rdata = {31'h0000_0000, pb_system_allocated};
        end
      end
      default: begin
        next_rdata = 32'h0000_0000;
      end
    endcase
  end

  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_rvalid_o <= 1'b0;
    end else begin
      cfg_rvalid_o <= cfg_rd_i;
    end
  end

  // data holds between reads so a late sampler still sees the last answer
  always_ff @(posedge clk_i or negedge rst_n_i) begin
    if (!rst_n_i) begin
      cfg_rdata_o <= 32'h0000_0000;
    end else if (cfg_rd_i) begin
      cfg_rdata_o <= next_rdata;
    end
  end
endmodule : pcrb_port_capability_register_bank

// file: sim/pcrb_checker.sv
`timescale 1ns/1ps
module pcrb_checker (
  input wire logic clk_i,
  input wire logic rst_n_i,
  input wire logic is_upstream_i,
  input wire logic is_function0_i,
  input wire logic link_speed_5g_i,
  input wire logic polling_compliance_i,
  input wire logic cfg_rd_i,
  input wire logic [11:0] cfg_addr_i,
  input wire logic init_wr_i,
  input wire logic [31:0] cfg_rdata_o,
  input wire logic cfg_rvalid_o,
  input wire logic deemph_3p5db_o,
  input wire logic enter_mod_compliance_o,
  input wire logic compliance_skip_insert_o,
  input wire logic [63:0] serial_number_o
);
  import pcrb_pkg::*;
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (!rst_n_i);
  // ----------------------------------------
  // read path and fixed headers
  // ----------------------------------------
  property p_rvalid; cfg_rvalid_o == $past(cfg_rd_i); endproperty
  a_rvalid: assert property (p_rvalid) else $error("read valid not one cycle after read");
  property p_subsys; cfg_rd_i && cfg_addr_i == OFF_SUBSYSTEM_CAPABILITY_HEADER |=> cfg_rdata_o == 32'h0000_000D; endproperty
  a_subsys: assert property (p_subsys) else $error("subsystem header wrong");
  property p_serial_hdr; cfg_rd_i && cfg_addr_i == 12'h100 |=> cfg_rdata_o == {12'hFB4, 4'h1, 16'h0003}; endproperty
  a_serial_hdr: assert property (p_serial_hdr) else $error("serial header wrong");
  property p_pwr_hdr;
    cfg_rd_i && cfg_addr_i == OFF_POWER_BUDGET_CAP_HEADER |=>
      cfg_rdata_o == (is_upstream_i ? {12'h148, 4'h1, 16'h0004} : 32'h0000_0000);
  endproperty
  a_pwr_hdr: assert property (p_pwr_hdr) else $error("power budget header wrong");
  property p_serial_low;
    cfg_rd_i && cfg_addr_i == OFF_SERIAL_NUMBER_LOW && !init_wr_i |=> cfg_rdata_o == $past(serial_number_o[31:0]);
  endproperty
  a_serial_low: assert property (p_serial_low) else $error("serial low word differs from shared value");
  // ----------------------------------------
  // link control/status 2
  // ----------------------------------------
  property p_lc2;
    cfg_rd_i && cfg_addr_i == OFF_LINK_STATUS_CONTROL_2 |=> !cfg_rdata_o[5] && cfg_rdata_o[16] == $past(deemph_3p5db_o);
  endproperty
  a_lc2: assert property (p_lc2) else $error("link status 2 bit 5 or 16 wrong");
  property p_lc2_down;
    cfg_rd_i && cfg_addr_i == OFF_LINK_STATUS_CONTROL_2 && !is_upstream_i |=> cfg_rdata_o[12:7] == 6'h00;
  endproperty
  a_lc2_down: assert property (p_lc2_down) else $error("upstream-only control bits set on downstream port");
  property p_slow; (!link_speed_5g_i && !polling_compliance_i) [*4] |=> deemph_3p5db_o; endproperty
  a_slow: assert property (p_slow) else $error("low speed not at -3.5 dB");
  property p_mod; !is_function0_i && $past(!is_function0_i) |-> !enter_mod_compliance_o; endproperty
  a_mod: assert property (p_mod) else $error("modified compliance outside function 0");
  property p_skip; !is_upstream_i && $past(!is_upstream_i) |-> !compliance_skip_insert_o; endproperty
  a_skip: assert property (p_skip) else $error("skip insertion on downstream port");
endmodule : pcrb_checker

bind pcrb_port_capability_register_bank pcrb_checker i_checker (.clk_i, .rst_n_i, .is_upstream_i, .is_function0_i,
  .link_speed_5g_i, .polling_compliance_i, .cfg_rd_i, .cfg_addr_i, .init_wr_i, .cfg_rdata_o, .cfg_rvalid_o,
  .deemph_3p5db_o, .enter_mod_compliance_o, .compliance_skip_insert_o, .serial_number_o);

// file: sim/pcrb_eeprom_model.sv
`timescale 1ns/1ps
module pcrb_eeprom_model #(
  parameter logic [31:0] ENTRY = 32'h0,
  parameter logic [63:0] SERIAL = 64'h0,
  parameter logic [31:0] BOARD = 32'h0,
  parameter int GAP = 2
) (
  input wire logic clk_i,
  input wire logic start_i,
  output logic init_wr_o,
  output logic [11:0] init_addr_o,
  output logic [31:0] init_wdata_o,
  output logic done_o
);
  // index 8 load is deliberately out of range, must be dropped
  logic [11:0] tab_a [9] = '{12'h13C, 12'h140, 12'h13C, 12'h140, 12'h104, 12'h108, 12'h0A8, 12'h098, 12'h13C};
  logic [31:0] tab_d [9] = '{32'h5, ENTRY, 32'h8, ~ENTRY, SERIAL[31:0], SERIAL[63:32], BOARD, 32'h1CD0, 32'h0};
  initial begin
    init_wr_o = 1'b0;
    init_addr_o = 12'h000;
    init_wdata_o = 32'h0;
    done_o = 1'b0;
    forever begin
      @(posedge clk_i);
      if (start_i) begin
        done_o = 1'b0;
        for (int i = 0; i < 9; i++) begin
          @(negedge clk_i);
          init_wr_o = 1'b1;
          init_addr_o = tab_a[i];
          init_wdata_o = tab_d[i];
          @(negedge clk_i);
          init_wr_o = 1'b0;
          // released bus shows garbage, not the last word
          init_addr_o = ~init_addr_o;
          init_wdata_o = ~init_wdata_o;
          repeat (GAP) @(negedge clk_i);
        end
        done_o = 1'b1;
      end
    end
  end
endmodule : pcrb_eeprom_model

// file: sim/port_capability_register_bank_test.sv
`timescale 1ns/1ps
module port_capability_register_bank_test;
  import pcrb_pkg::*;
  localparam logic [31:0] PB_V = {11'h7FF, 3'b010, 3'b111, 2'b11, 3'b101, 2'b11, 8'hA5};
  localparam logic [63:0] SN = 64'h0123_4567_89AB_CDEF;
  localparam logic [31:0] BRD = 32'h5A5A_C3C3;
  logic clk_i = 1'b0, rst_n_i = 1'b0, is_upstream_i = 1'b1, is_function0_i = 1'b1, start = 1'b0;
  logic link_speed_5g_i = 1'b0, polling_compliance_i = 1'b0, cfg_wr_i = 1'b0, cfg_rd_i = 1'b0;
  logic [11:0] cfg_addr_i = 12'h000, init_addr_i;
  logic [31:0] cfg_wdata_i = 32'h0, init_wdata_i, cfg_rdata_o;
  logic init_wr_i, cfg_rvalid_o, deemph_3p5db_o, enter_compliance_o, enter_mod_compliance_o;
  logic compliance_skip_insert_o, done;
  logic [2:0] tx_margin_o;
  logic [63:0] serial_number_o;
  int fail_count = 0, n_checks = 0;
  always #2.5 clk_i = ~clk_i;
  pcrb_port_capability_register_bank i_dut (.clk_i, .rst_n_i, .is_upstream_i, .is_function0_i, .link_speed_5g_i,
    .polling_compliance_i, .cfg_wr_i, .cfg_rd_i, .cfg_addr_i, .cfg_wdata_i, .init_wr_i, .init_addr_i, .init_wdata_i,
    .cfg_rdata_o, .cfg_rvalid_o, .deemph_3p5db_o, .enter_compliance_o, .enter_mod_compliance_o,
    .compliance_skip_insert_o, .tx_margin_o, .serial_number_o);
  pcrb_eeprom_model #(.ENTRY(PB_V), .SERIAL(SN), .BOARD(BRD), .GAP(3)) i_eeprom (.clk_i, .start_i(start),
    .init_wr_o(init_wr_i), .init_addr_o(init_addr_i), .init_wdata_o(init_wdata_i), .done_o(done));
  // ----------------------------------------
  // access tasks
  // ----------------------------------------
  task automatic check(input string what, input logic [63:0] exp, input logic [63:0] got);
    n_checks++;
    if (got !== exp) begin
      fail_count++;
      $display("mismatch %s expected %h seen %h", what, exp, got);
    end
  endtask : check
  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    @(negedge clk_i);
    cfg_wr_i = 1'b1;
    cfg_addr_i = a;
    cfg_wdata_i = d;
    @(negedge clk_i);
    cfg_wr_i = 1'b0;
    cfg_wdata_i = ~d;
  endtask : wr
  task automatic rd(input logic [11:0] a, input logic [31:0] exp);
    @(negedge clk_i);
    cfg_rd_i = 1'b1;
    cfg_addr_i = a;
    @(negedge clk_i);
    cfg_rd_i = 1'b0;
    check("read valid", 64'h1, {63'h0, cfg_rvalid_o});
    check($sformatf("register %h", a), {32'h0, exp}, {32'h0, cfg_rdata_o});
  endtask : rd
  task automatic load;
    @(negedge clk_i);
    start = 1'b1;
    @(negedge clk_i);
    start = 1'b0;
    for (int i = 0; i < 200 && done !== 1'b1; i++) @(negedge clk_i);
    check("init load done", 64'h1, {63'h0, done});
  endtask : load
  task automatic results;
    $display("checks %0d mismatches %0d", n_checks, fail_count);
    if (fail_count == 0 && n_checks > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask : results
  // ----------------------------------------
  // tests
  // ----------------------------------------
  initial begin
    repeat (4) @(negedge clk_i);
    rst_n_i = 1'b1;
    rd(OFF_SUBSYSTEM_CAPABILITY_HEADER, 32'h0000_000D);
    rd(OFF_SERIAL_NUMBER_CAP_HEADER, {12'hFB4, 4'h1, 16'h0003});
    rd(OFF_POWER_BUDGET_CAP_HEADER, {12'h148, 4'h1, 16'h0004});
    rd(OFF_POWER_BUDGET_INDEX, 32'h0);
    rd(OFF_POWER_BUDGET_CAPABILITY, 32'h1);
    rd(OFF_LINK_STATUS_CONTROL_2, 32'h0001_0000);
    load();
    rd(OFF_POWER_BUDGET_ENTRY, 32'h0);
    wr(OFF_POWER_BUDGET_INDEX, 32'h5);
    rd(OFF_POWER_BUDGET_ENTRY, PB_V & 32'h001F_FFFF);
    wr(OFF_POWER_BUDGET_ENTRY, 32'h0);
    rd(OFF_POWER_BUDGET_ENTRY, PB_V & 32'h001F_FFFF);
    wr(OFF_POWER_BUDGET_INDEX, 32'h8);
    rd(OFF_POWER_BUDGET_ENTRY, 32'h0);
    wr(OFF_POWER_BUDGET_INDEX, 32'hFF);
    rd(OFF_POWER_BUDGET_INDEX, 32'hFF);
    rd(OFF_SERIAL_NUMBER_HIGH, SN[63:32]);
    wr(OFF_SERIAL_NUMBER_LOW, 32'h0);
    rd(OFF_SERIAL_NUMBER_LOW, SN[31:0]);
    check("serial number", SN, serial_number_o);
    wr(OFF_BOARD_VENDOR_AND_BOARD_ID, 32'h0);
    rd(OFF_BOARD_VENDOR_AND_BOARD_ID, BRD);
    rd(OFF_LINK_STATUS_CONTROL_2, 32'h0001_1C90);
    check("skip insert", 64'h1, {63'h0, compliance_skip_insert_o});
    check("enter compliance", 64'h1, {63'h0, enter_compliance_o});
    check("transmit margin", 64'h1, {61'h0, tx_margin_o});
    check("modified compliance", 64'h1, {63'h0, enter_mod_compliance_o});
    is_function0_i = 1'b0;
    repeat (2) @(negedge clk_i);
    check("modified compliance", 64'h0, {63'h0, enter_mod_compliance_o});
    link_speed_5g_i = 1'b1;
    repeat (4) @(negedge clk_i);
    check("de-emphasis 5G", 64'h0, {63'h0, deemph_3p5db_o});
    polling_compliance_i = 1'b1;
    repeat (2) @(negedge clk_i);
    check("compliance de-emphasis", 64'h1, {63'h0, deemph_3p5db_o});
    polling_compliance_i = 1'b0;
    wr(OFF_LINK_STATUS_CONTROL_2, 32'h0000_1C00);
    polling_compliance_i = 1'b1;
    repeat (2) @(negedge clk_i);
    check("compliance without entry bit", 64'h0, {63'h0, deemph_3p5db_o});
    check("enter compliance cleared", 64'h0, {63'h0, enter_compliance_o});
    polling_compliance_i = 1'b0;
    // second life as a downstream port
    rst_n_i = 1'b0;
    is_upstream_i = 1'b0;
    repeat (2) @(negedge clk_i);
    rst_n_i = 1'b1;
    repeat (4) @(negedge clk_i);
    check("downstream -6 dB", 64'h0, {63'h0, deemph_3p5db_o});
    load();
    repeat (2) @(negedge clk_i);
    check("downstream selected -3.5 dB", 64'h1, {63'h0, deemph_3p5db_o});
    check("downstream margin", 64'h0, {61'h0, tx_margin_o});
    rd(OFF_LINK_STATUS_CONTROL_2, 32'h0001_0050);
    rd(OFF_POWER_BUDGET_CAP_HEADER, 32'h0);
    rd(OFF_POWER_BUDGET_CAPABILITY, 32'h0);
    rd(OFF_SERIAL_NUMBER_HIGH, SN[63:32]);
    results();
  end
  initial begin
    #50000;
    fail_count++;
    results();
  end
endmodule : port_capability_register_bank_test
